/* File: design/ses_pkg.sv */
// Functional notes
// - input bits taken on rising serial clock, msb first; first eight form the opcode
// - serial output changes on the falling serial clock edge; select high clears it
// - stopped serial clock holds all transfer state; resumes at same bit
// - 06 sets latch; 04 clears latch and cause flag; 00 sets cause flag
// - 05 shifts status word out; 01 writes period, range, lock and flag fields
// - 03 reads array, 02 writes array, from address following the opcode
// - writes need latch set; latch clears at power-up and after write completes
// - status bits 7..0: lock, flag, period hi/lo, range hi/lo, latch, busy
// - status readable anytime; busy bit is one during a write
// - range 00 none, 01 0600-07FF, 10 0400-07FF, 11 0000-07FF
// - protected addresses read normally but ignore writes
// - period 00 1.4 s, 01 600 ms, 10 200 ms, 11 watchdog off
// - falling select restarts watchdog; expiry asserts supervisor reset
// - cause flag volatile, set and cleared by commands, cleared at power-up
// - latch clear blocks all writes; lock bit with low lock pin blocks status
// - lock pin falling during status write lets it finish, blocks later ones
// - reset asserts while supply low; releases after 200 ms above threshold
// - array read streams bytes, address increments, wraps top to zero
// - write commits only if select rises after bit 0; page wrap
package ses_pkg;

  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SET_WEL  = 8'h06;
  localparam logic [7:0] OP_CLR_WEL  = 8'h04;
  localparam logic [7:0] OP_SET_FLAG = 8'h00;
  localparam logic [7:0] OP_RD_STAT  = 8'h05;
  localparam logic [7:0] OP_WR_STAT  = 8'h01;
  localparam logic [7:0] OP_RD_ARR   = 8'h03;
  localparam logic [7:0] OP_WR_ARR   = 8'h02;

  // ----------------------------------------------------------------
  // geometry and frame bit counts
  // ----------------------------------------------------------------
  localparam int         ARR_AW         = 11;
  localparam int         PAGE_AW        = 5;
  localparam logic [4:0] CNT_OP_LAST    = 5'h07;
  localparam logic [4:0] CNT_ADDR_LAST  = 5'h17;
  localparam logic [4:0] CNT_DATA_FIRST = 5'h18;
  localparam logic [2:0] BIT_LAST       = 3'h7;
  localparam logic [5:0] PAGE_BYTES     = 6'h20;

  // ----------------------------------------------------------------
  // status word layout and encodings
  // ----------------------------------------------------------------
  localparam int ST_LOCK  = 7;
  localparam int ST_FLAG  = 6;
  localparam int ST_WD_HI = 5;
  localparam int ST_WD_LO = 4;
  localparam int ST_BL_HI = 3;
  localparam int ST_BL_LO = 2;
  localparam int ST_WEL   = 1;
  localparam int ST_BUSY  = 0;
  localparam logic [1:0] BL_QUARTER = 2'h1;
  localparam logic [1:0] BL_HALF    = 2'h2;
  localparam logic [1:0] BL_ALL     = 2'h3;
  localparam logic [1:0] BL_TOP2    = 2'h3;
  localparam logic [1:0] WD_LONG    = 2'h0;
  localparam logic [1:0] WD_MID     = 2'h1;
  localparam logic [1:0] WD_SHORT   = 2'h2;
  // nonvolatile field values after power-up
  localparam logic       NV_LOCK_RST = 1'h0;
  localparam logic [1:0] NV_WD_RST   = 2'h3;
  localparam logic [1:0] NV_BL_RST   = 2'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CNT_W       = 24;
  localparam int CLK_HZ      = 10_000_000;
  localparam int CYC_PER_MS  = CLK_HZ / 1000;
  localparam int WDT_LONG_MS = 1400;
  localparam int WDT_MID_MS  = 600;
  localparam int WDT_SHRT_MS = 200;
  localparam int POR_MS      = 200;
  localparam int WR_TIME_MS  = 5;
  localparam logic [CNT_W-1:0] WDT_LONG_CYC_DEF =
    CNT_W'(WDT_LONG_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] WDT_MID_CYC_DEF  =
    CNT_W'(WDT_MID_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] WDT_SHRT_CYC_DEF =
    CNT_W'(WDT_SHRT_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] POR_CYC_DEF      =
    CNT_W'(POR_MS * CYC_PER_MS);
  localparam logic [CNT_W-1:0] WR_CYC_DEF       =
    CNT_W'(WR_TIME_MS * CYC_PER_MS);

  // ----------------------------------------------------------------
  // commit engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CM_IDLE = 3'h1,
    CM_COPY = 3'h2,
    CM_WAIT = 3'h4
  } ses_commit_t;

  // protected-range test for one array address
  function automatic logic ses_locked(input logic [1:0]        bl,
                                      input logic [ARR_AW-1:0] a);
    ses_locked = (bl == BL_ALL) ||
                 (bl == BL_HALF && a[ARR_AW-1]) ||
                 (bl == BL_QUARTER && a[ARR_AW-1 -: 2] == BL_TOP2);
  endfunction

endpackage

/* File: design/ses_mem_if.sv */
`timescale 1ns/100ps
// byte memory port: write side and read side on their own clocks
interface ses_mem_if #(parameter int AW = 11);
  logic          wclk;
  logic          we;
  logic [AW-1:0] waddr;
  logic [7:0]    wdata;
  logic          rclk;
  logic          re;
  logic [AW-1:0] raddr;
  logic [7:0]    rdata;
  modport user (output wclk, we, waddr, wdata, rclk, re, raddr,
                input rdata);
  modport mem  (input wclk, we, waddr, wdata, rclk, re, raddr,
                output rdata);
endinterface

/* File: design/ses_mem.sv */
`timescale 1ns/100ps
// byte array with registered read data
module ses_mem #(
  parameter int AW = 11
) (
  ses_mem_if.mem port
);
  logic [7:0] cells [0:(1<<AW)-1];
  logic [7:0] rdata_q;

  // write port
  always_ff @(posedge port.wclk) begin
    if (port.we) begin
      cells[port.waddr] <= port.wdata;
    end
  end

  // read port, data held between reads
  always_ff @(posedge port.rclk) begin
    if (port.re) begin
      rdata_q <= cells[port.raddr];
    end
  end

  assign port.rdata = rdata_q;
endmodule

/* File: design/ses_top.sv */
`timescale 1ns/100ps
module ses_top
  import ses_pkg::*;
#(
  parameter logic [CNT_W-1:0] WDT_LONG_CYC = WDT_LONG_CYC_DEF,
  parameter logic [CNT_W-1:0] WDT_MID_CYC  = WDT_MID_CYC_DEF,
  parameter logic [CNT_W-1:0] WDT_SHRT_CYC = WDT_SHRT_CYC_DEF,
  parameter logic [CNT_W-1:0] POR_CYC      = POR_CYC_DEF,
  parameter logic [CNT_W-1:0] WR_CYC       = WR_CYC_DEF
) (
  input  wire logic clk_in,
  input  wire logic reset_n_in,
  input  wire logic sck_in,
  input  wire logic select_kick_n_in,
  input  wire logic si_in,
  input  wire logic lock_n_in,
  input  wire logic supply_ok_in,
  output logic      so_out,
  output logic      so_oe_out,
  output logic      supervisor_reset_out
);

  // ----------------------------------------------------------------
  // memories: array written by clk_in, read by sck; page the reverse
  // ----------------------------------------------------------------
  ses_mem_if #(.AW(ARR_AW))  arr_if ();
  ses_mem_if #(.AW(PAGE_AW)) pg_if ();
  ses_mem #(.AW(ARR_AW))  u_arr (.port(arr_if.mem));
  ses_mem #(.AW(PAGE_AW)) u_page (.port(pg_if.mem));

  // ----------------------------------------------------------------
  // serial clock domain
  // ----------------------------------------------------------------
  logic              fresh_q;
  logic [4:0]        cnt_q, cnt_d, cnt_cur;
  logic [7:0]        shift_q, sh, op_q, op_d;
  logic [15:0]       addr_q, addr_d, addr_sh;
  logic [ARR_AW-1:0] start_q, start_d, arr_raddr;
  logic [5:0]        nbytes_q, nbytes_d;
  logic              aligned_q, aligned_d, tog_q, tog_d, arr_re, pg_we;
  logic [7:0]        sdata_q, sdata_d, stat_out_q, stat_out_d;
  logic [7:0]        stat_s1_q, stat_s2_q, status_q, status_d;
  logic              busy_s1_q, busy_s2_q;
  logic              so_q, so_d, so_oe_q, so_oe_d, rd_op;
  logic [7:0]        rd_src;

  // select high marks the next edge as bit 0 of a new frame
  always_ff @(posedge sck_in or posedge select_kick_n_in) begin
    if (select_kick_n_in) begin
      fresh_q <= 1'b1;
    end else begin
      fresh_q <= 1'b0;
    end
  end

  // frame decode; nothing moves without a clock edge
  always_comb begin
    sh         = {shift_q[6:0], si_in};
    cnt_cur    = fresh_q ? '0 : cnt_q;
    addr_sh    = {addr_q[14:0], si_in};
    cnt_d      = cnt_q;
    op_d       = op_q;
    addr_d     = addr_q;
    start_d    = start_q;
    nbytes_d   = fresh_q ? '0 : nbytes_q;
    aligned_d  = 1'b0;
    tog_d      = tog_q;
    sdata_d    = sdata_q;
    stat_out_d = stat_out_q;
    arr_re     = 1'b0;
    arr_raddr  = addr_q[ARR_AW-1:0];
    pg_we      = 1'b0;
    if (cnt_cur < CNT_OP_LAST) begin
      cnt_d = cnt_cur + 5'h01;
    end else if (cnt_cur == CNT_OP_LAST) begin
      op_d       = sh;
      tog_d      = ~tog_q;
      stat_out_d = stat_s2_q;
      cnt_d      = (sh == OP_RD_ARR || sh == OP_WR_ARR) ?
                   cnt_cur + 5'h01 : CNT_DATA_FIRST;
    end else if (cnt_cur < CNT_DATA_FIRST) begin
      cnt_d  = cnt_cur + 5'h01;
      addr_d = addr_sh;
      if (cnt_cur == CNT_ADDR_LAST) begin
        arr_re    = (op_q == OP_RD_ARR);
        arr_raddr = addr_sh[ARR_AW-1:0];
        start_d   = addr_sh[ARR_AW-1:0];
      end
    end else begin
      cnt_d = cnt_cur + 5'h01;
      if (cnt_cur[2:0] == BIT_LAST) begin
        cnt_d      = CNT_DATA_FIRST;
        aligned_d  = 1'b1;
        stat_out_d = stat_s2_q;
        if (op_q == OP_RD_ARR) begin
          addr_d[ARR_AW-1:0] = addr_q[ARR_AW-1:0] + 11'h001;
          arr_re    = 1'b1;
          arr_raddr = addr_d[ARR_AW-1:0];
        end
        if (op_q == OP_WR_ARR && !busy_s2_q) begin
          pg_we = 1'b1;
          addr_d[PAGE_AW-1:0] = addr_q[PAGE_AW-1:0] + 5'h01;
          if (nbytes_q != PAGE_BYTES) begin
            nbytes_d = nbytes_q + 6'h01;
          end
        end
        if (op_q == OP_WR_STAT && nbytes_q == '0) begin
          sdata_d  = sh;
          nbytes_d = 6'h01;
        end
      end
    end
  end

  // frame registers, held while the clock stands still
  always_ff @(posedge sck_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cnt_q      <= '0;
      shift_q    <= '0;
      op_q       <= '0;
      addr_q     <= '0;
      start_q    <= '0;
      nbytes_q   <= '0;
      aligned_q  <= 1'b0;
      tog_q      <= 1'b0;
      sdata_q    <= '0;
      stat_out_q <= '0;
      stat_s1_q  <= '0;
      stat_s2_q  <= '0;
      busy_s1_q  <= 1'b0;
      busy_s2_q  <= 1'b0;
    end else begin
      cnt_q      <= cnt_d;
      shift_q    <= sh;
      op_q       <= op_d;
      addr_q     <= addr_d;
      start_q    <= start_d;
      nbytes_q   <= nbytes_d;
      aligned_q  <= aligned_d;
      tog_q      <= tog_d;
      sdata_q    <= sdata_d;
      stat_out_q <= stat_out_d;
      stat_s1_q  <= status_q;
      stat_s2_q  <= stat_s1_q;
      busy_s1_q  <= status_q[ST_BUSY];
      busy_s2_q  <= busy_s1_q;
    end
  end

  // output bit for the falling edge
  always_comb begin
    rd_op   = (op_q == OP_RD_ARR) || (op_q == OP_RD_STAT);
    rd_src  = (op_q == OP_RD_ARR) ? arr_if.rdata : stat_out_q;
    so_d    = 1'b0;
    so_oe_d = 1'b0;
    if (!fresh_q && rd_op && cnt_q >= CNT_DATA_FIRST) begin
      so_oe_d = 1'b1;
      so_d    = rd_src[~cnt_q[2:0]];
    end
  end

  // output register on the falling edge, released by select high
  always_ff @(negedge sck_in or posedge select_kick_n_in) begin
    if (select_kick_n_in) begin
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end else begin
      so_q    <= so_d;
      so_oe_q <= so_oe_d;
    end
  end

  // ----------------------------------------------------------------
  // system clock domain
  // ----------------------------------------------------------------
  logic              cs_s1_q, cs_s2_q, cs_prev_q, lock_s1_q, lock_s2_q;
  logic              sup_s1_q, sup_s2_q, tog_s1_q, tog_s2_q;
  logic              seen_q, seen_d, cs_rise, cs_fall, single, wr_gate;
  logic              wel_q, wel_d, flag_q, flag_d, lock_en_q, lock_en_d;
  logic [1:0]        wd_q, wd_d, bl_q, bl_d;
  ses_commit_t       state_q, state_d;
  logic [5:0]        idx_q, idx_d, cm_n_q, cm_n_d;
  logic [ARR_AW-1:0] cm_start_q, cm_start_d, arr_waddr;
  logic              cm_stat_q, cm_stat_d, arr_we;
  logic [7:0]        cm_sdata_q, cm_sdata_d;
  logic [CNT_W-1:0]  wait_q, wait_d, wdt_q, wdt_d, por_q, por_d, wdt_lim;
  logic              rst_q, rst_d, wdt_fire;

  // input synchronisers
  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      cs_s1_q   <= 1'b1;
      cs_s2_q   <= 1'b1;
      cs_prev_q <= 1'b1;
      lock_s1_q <= 1'b1;
      lock_s2_q <= 1'b1;
      sup_s1_q  <= 1'b0;
      sup_s2_q  <= 1'b0;
      tog_s1_q  <= 1'b0;
      tog_s2_q  <= 1'b0;
    end else begin
      cs_s1_q   <= select_kick_n_in;
      cs_s2_q   <= cs_s1_q;
      cs_prev_q <= cs_s2_q;
      lock_s1_q <= lock_n_in;
      lock_s2_q <= lock_s1_q;
      sup_s1_q  <= supply_ok_in;
      sup_s2_q  <= sup_s1_q;
      tog_s1_q  <= tog_q;
      tog_s2_q  <= tog_s1_q;
    end
  end

  assign cs_rise = cs_s2_q && !cs_prev_q;
  assign cs_fall = !cs_s2_q && cs_prev_q;

  // commands, commit engine, status word
  always_comb begin
    single     = (tog_s2_q != seen_q) && (cnt_q == CNT_DATA_FIRST) &&
                 !aligned_q && nbytes_q == '0;
    wr_gate    = !(lock_en_q && !lock_s2_q);
    seen_d     = seen_q;
    wel_d      = wel_q;
    flag_d     = flag_q;
    lock_en_d  = lock_en_q;
    wd_d       = wd_q;
    bl_d       = bl_q;
    state_d    = state_q;
    idx_d      = idx_q;
    cm_n_d     = cm_n_q;
    cm_start_d = cm_start_q;
    cm_stat_d  = cm_stat_q;
    cm_sdata_d = cm_sdata_q;
    wait_d     = wait_q;
    arr_waddr  = {cm_start_q[ARR_AW-1:PAGE_AW],
                  cm_start_q[PAGE_AW-1:0] + idx_q[4:0] - 5'h01};
    arr_we     = 1'b0;
    case (state_q)
      CM_COPY: begin
        if (idx_q != '0) begin
          arr_we = !ses_locked(bl_q, arr_waddr);
        end
        if (idx_q == cm_n_q) begin
          state_d = CM_WAIT;
          wait_d  = '0;
        end else begin
          idx_d = idx_q + 6'h01;
        end
      end
      CM_WAIT: begin
        wait_d = wait_q + 1'b1;
        if (wait_q == WR_CYC - 1'b1) begin
          state_d = CM_IDLE;
          wel_d   = 1'b0;
          if (cm_stat_q) begin
            lock_en_d = cm_sdata_q[ST_LOCK];
            flag_d    = cm_sdata_q[ST_FLAG];
            wd_d      = cm_sdata_q[ST_WD_HI:ST_WD_LO];
            bl_d      = cm_sdata_q[ST_BL_HI:ST_BL_LO];
          end
        end
      end
      default: begin
        state_d = CM_IDLE;
      end
    endcase
    if (cs_rise && tog_s2_q != seen_q) begin
      seen_d = tog_s2_q;
      if (single && op_q == OP_SET_WEL) begin
        wel_d = 1'b1;
      end else if (single && op_q == OP_CLR_WEL) begin
        wel_d  = 1'b0;
        flag_d = 1'b0;
      end else if (single && op_q == OP_SET_FLAG) begin
        flag_d = 1'b1;
      end else if (state_q == CM_IDLE && wel_q && aligned_q &&
                   nbytes_q != '0) begin
        cm_start_d = start_q;
        cm_n_d     = nbytes_q;
        cm_sdata_d = sdata_q;
        idx_d      = '0;
        if (op_q == OP_WR_ARR) begin
          state_d   = CM_COPY;
          cm_stat_d = 1'b0;
        end else if (op_q == OP_WR_STAT && wr_gate) begin
          state_d   = CM_COPY;
          cm_stat_d = 1'b1;
          cm_n_d    = '0;
        end
      end
    end
    status_d = {lock_en_q, flag_q, wd_q, bl_q, wel_q,
                state_q != CM_IDLE};
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      seen_q     <= 1'b0;
      wel_q      <= 1'b0;
      flag_q     <= 1'b0;
      lock_en_q  <= NV_LOCK_RST;
      wd_q       <= NV_WD_RST;
      bl_q       <= NV_BL_RST;
      state_q    <= CM_IDLE;
      idx_q      <= '0;
      cm_n_q     <= '0;
      cm_start_q <= '0;
      cm_stat_q  <= 1'b0;
      cm_sdata_q <= '0;
      wait_q     <= '0;
      status_q   <= '0;
    end else begin
      seen_q     <= seen_d;
      wel_q      <= wel_d;
      flag_q     <= flag_d;
      lock_en_q  <= lock_en_d;
      wd_q       <= wd_d;
      bl_q       <= bl_d;
      state_q    <= state_d;
      idx_q      <= idx_d;
      cm_n_q     <= cm_n_d;
      cm_start_q <= cm_start_d;
      cm_stat_q  <= cm_stat_d;
      cm_sdata_q <= cm_sdata_d;
      wait_q     <= wait_d;
      status_q   <= status_d;
    end
  end

  // memory port wiring
  assign arr_if.wclk  = clk_in;
  assign arr_if.we    = arr_we;
  assign arr_if.waddr = arr_waddr;
  assign arr_if.wdata = pg_if.rdata;
  assign arr_if.rclk  = sck_in;
  assign arr_if.re    = arr_re;
  assign arr_if.raddr = arr_raddr;
  assign pg_if.wclk   = sck_in;
  assign pg_if.we     = pg_we;
  assign pg_if.waddr  = addr_q[PAGE_AW-1:0];
  assign pg_if.wdata  = sh;
  assign pg_if.rclk   = clk_in;
  assign pg_if.re     = (state_q == CM_COPY) && (idx_q != cm_n_q);
  assign pg_if.raddr  = cm_start_q[PAGE_AW-1:0] + idx_q[4:0];

  // watchdog and supervisor reset
  always_comb begin
    case (wd_q)
      WD_LONG:  wdt_lim = WDT_LONG_CYC;
      WD_MID:   wdt_lim = WDT_MID_CYC;
      WD_SHORT: wdt_lim = WDT_SHRT_CYC;
      default:  wdt_lim = '0;
    endcase
    wdt_fire = (wdt_lim != '0) && (wdt_q == wdt_lim - 1'b1) && !cs_fall;
    wdt_d    = (rst_q || cs_fall || wdt_lim == '0 || wdt_fire) ?
               '0 : wdt_q + 1'b1;
    rst_d    = rst_q;
    por_d    = por_q;
    if (!sup_s2_q || wdt_fire) begin
      rst_d = 1'b1;
      por_d = '0;
    end else if (rst_q) begin
      por_d = por_q + 1'b1;
      if (por_q == POR_CYC - 1'b1) begin
        rst_d = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wdt_q <= '0;
      por_q <= '0;
      rst_q <= 1'b1;
    end else begin
      wdt_q <= wdt_d;
      por_q <= por_d;
      rst_q <= rst_d;
    end
  end

  assign so_out               = so_q;
  assign so_oe_out            = so_oe_q;
  assign supervisor_reset_out = rst_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  sequence s_end_single(logic [7:0] op);
    cs_rise && single && op_q == op;
  endsequence
  sequence s_commit_done;
    state_q == CM_WAIT && wait_q == WR_CYC - 1'b1;
  endsequence

  property p_set_wel;
    @(posedge clk_in) disable iff (!reset_n_in)
    s_end_single(OP_SET_WEL) |=> wel_q ##1 status_q[ST_WEL];
  endproperty
  a_set_wel: assert property (p_set_wel) else $error("latch not set");
  property p_clr_both;
    @(posedge clk_in) disable iff (!reset_n_in)
    s_end_single(OP_CLR_WEL) |=> !wel_q && !flag_q;
  endproperty
  a_clr_both: assert property (p_clr_both) else $error("clear failed");
  property p_need_wel;
    @(posedge clk_in) disable iff (!reset_n_in)
    cs_rise && !wel_q && state_q == CM_IDLE |=> state_q == CM_IDLE;
  endproperty
  a_need_wel: assert property (p_need_wel) else $error("write w/o latch");
  property p_autoclr;
    @(posedge clk_in) disable iff (!reset_n_in)
    s_commit_done and !cs_rise |=> !wel_q && state_q == CM_IDLE;
  endproperty
  a_autoclr: assert property (p_autoclr) else $error("latch kept");
  property p_busy;
    @(posedge clk_in) disable iff (!reset_n_in)
    state_q != CM_IDLE |=> status_q[ST_BUSY];
  endproperty
  a_busy: assert property (p_busy) else $error("busy bit low");
  // range bases written out apart from the decode function
  localparam logic [ARR_AW-1:0] HALF_BASE    = 11'h400;
  localparam logic [ARR_AW-1:0] QUARTER_BASE = 11'h600;
  property p_protect;
    @(posedge clk_in) disable iff (!reset_n_in)
    arr_we |-> bl_q != BL_ALL &&
               !(bl_q == BL_HALF && arr_waddr >= HALF_BASE) &&
               !(bl_q == BL_QUARTER && arr_waddr >= QUARTER_BASE);
  endproperty
  a_protect: assert property (p_protect) else $error("locked write");
  property p_lock;
    @(posedge clk_in) disable iff (!reset_n_in)
    cs_rise && op_q == OP_WR_STAT && lock_en_q && !lock_s2_q &&
    state_q == CM_IDLE |=> state_q == CM_IDLE;
  endproperty
  a_lock: assert property (p_lock) else $error("status not locked");
  property p_supply;
    @(posedge clk_in) disable iff (!reset_n_in)
    !sup_s2_q |=> rst_q [*2];
  endproperty
  a_supply: assert property (p_supply) else $error("reset not held");
  property p_release;
    @(posedge clk_in) disable iff (!reset_n_in)
    $fell(rst_q) |-> $past(por_q) == POR_CYC - 1'b1;
  endproperty
  a_release: assert property (p_release) else $error("early release");
  property p_kick;
    @(posedge clk_in) disable iff (!reset_n_in)
    cs_fall |=> wdt_q == '0;
  endproperty
  a_kick: assert property (p_kick) else $error("kick ignored");
  property p_rd_inc;
    @(posedge sck_in) disable iff (!reset_n_in)
    !fresh_q && op_q == OP_RD_ARR && cnt_q >= CNT_DATA_FIRST &&
    cnt_q[2:0] == BIT_LAST |=>
    addr_q[ARR_AW-1:0] == $past(addr_q[ARR_AW-1:0]) + 11'h001;
  endproperty
  a_rd_inc: assert property (p_rd_inc) else $error("no increment");
endmodule

/* File: bench/ses_host.sv */
`timescale 1ns/100ps
// spi host, mode 0: sck rests low outside frames
module ses_host (
  output logic      sck_out,
  output logic      cs_n_out,
  output logic      si_out,
  input  wire logic so_in
);
  // idle levels
  initial begin
    sck_out  = 1'b0;
    cs_n_out = 1'b1;
    si_out   = 1'b0;
  end
  // one frame of n bits, msb first; stall stops sck mid frame
  task automatic xfer(input int n, input logic [47:0] tx,
                      output logic [47:0] rx, input bit stall);
    rx = '0;
    cs_n_out = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si_out = tx[i];
      #7.5;
      rx = {rx[46:0], so_in};
      sck_out = 1'b1;
      #7.5 sck_out = 1'b0;
      if (stall && i == 20) #400;
    end
    #7.5 cs_n_out = 1'b1;
    si_out = ~si_out; // no stale level after release
    #500;
  endtask
endmodule

/* File: bench/ses_top_tb.sv */
`timescale 1ns/100ps
module ses_top_tb;
  import ses_pkg::*;
  logic        clk_in       = 1'b0;
  logic        reset_n_in   = 1'b0;
  logic        lock_n_in    = 1'b1;
  logic        supply_ok_in = 1'b1;
  logic        sck, cs_n, si, so, so_oe, rst;
  int          mismatches   = 0;
  int          n_tests      = 0;
  int          cyc          = 0;
  int          mem_m [int];
  int          bl_m         = 0;
  logic [7:0]  st_m;
  logic [7:0]  d0, d1, d2;
  logic [47:0] rx;
  logic [7:0]  ops [3] = '{OP_SET_WEL, OP_SET_FLAG, OP_CLR_WEL};
  logic [7:0]  exs [3] = '{8'h32, 8'h72, 8'h30};

  always #50 clk_in = ~clk_in;

  ses_top #(.WDT_LONG_CYC(24'h190), .WDT_MID_CYC(24'h12C),
    .WDT_SHRT_CYC(24'hC8), .POR_CYC(24'h32), .WR_CYC(24'h14)) ses_top_i (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .sck_in(sck),
    .select_kick_n_in(cs_n), .si_in(si), .lock_n_in(lock_n_in),
    .supply_ok_in(supply_ok_in), .so_out(so), .so_oe_out(so_oe),
    .supervisor_reset_out(rst));
  ses_host ses_host_i (.sck_out(sck), .cs_n_out(cs_n), .si_out(si),
    .so_in(so));

  // hang limit
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // reference model: bytes in the protected range are dropped
  function automatic void mdl_wr(input int a, input int d);
    if (!(bl_m == 3 || (bl_m == 2 && a >= 'h400) ||
          (bl_m == 1 && a >= 'h600)))
      mem_m[a] = d;
  endfunction
  task automatic end_of_test();
    $display("%0d checks, %0d mismatches", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic xf(input int n, input logic [47:0] tx);
    ses_host_i.xfer(n, tx, rx, 1'b0);
  endtask
  task automatic rd_st();
    xf(16, 48'({OP_RD_STAT, 8'h00}));
  endtask
  task automatic wait_done();
    int k;
    k = 0;
    do begin
      rd_st();
      k++;
    end while (rx[ST_BUSY] === 1'b1 && k < 60);
  endtask
  // latch set, write frame, busy seen, then latch gone
  task automatic wr(input int n, input logic [47:0] tx);
    xf(8, 48'(OP_SET_WEL));
    xf(n, tx);
    rd_st();
    check({6'h00, rx[1:0]}, 8'h03);
    wait_done();
    check(rx[7:0], st_m);
  endtask
  // reset held, then released after the supply hold time
  task automatic por_chk();
    repeat (40) @(negedge clk_in);
    check({7'h00, rst}, 8'h01);
    repeat (25) @(negedge clk_in);
    check({7'h00, rst}, 8'h00);
  endtask
  task automatic rd3();
    int q [$];
    q = '{mem_m['h7FE], mem_m['h7FF], mem_m['h000]};
    ses_host_i.xfer(48, 48'({OP_RD_ARR, 16'h07FE, 24'h0}), rx, 1'b1);
    check(rx[23:16], 8'(q[0]));
    check(rx[15:8], 8'(q[1]));
    check(rx[7:0], 8'(q[2]));
    check({7'h00, so_oe}, 8'h00);
  endtask

  // main sequence
  initial begin
    void'($urandom(32'h1524758d));
    st_m = 8'h30;
    repeat (5) @(posedge clk_in);
    @(negedge clk_in) reset_n_in = 1'b1;
    por_chk();
    supply_ok_in = 1'b0;
    repeat (5) @(negedge clk_in);
    check({7'h00, rst}, 8'h01);
    supply_ok_in = 1'b1;
    por_chk();
    $display("test power done");
    rd_st();
    check(rx[7:0], st_m);
    for (int i = 0; i < 3; i++) begin
      xf(8, 48'(ops[i]));
      rd_st();
      check(rx[7:0], exs[i]);
    end
    $display("test commands done");
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    d2 = 8'($urandom);
    wr(40, {8'h0, OP_WR_ARR, 16'h07FE, d0, d1});
    mdl_wr('h7FE, d0);
    mdl_wr('h7FF, d1);
    wr(32, 48'({OP_WR_ARR, 16'h0000, d2}));
    mdl_wr('h000, d2);
    rd3();
    st_m = 8'h34;
    wr(16, 48'({OP_WR_STAT, st_m}));
    bl_m = st_m[3:2];
    xf(8, 48'(OP_SET_WEL));
    xf(32, 48'({OP_WR_ARR, 16'h07FF, ~d1}));
    mdl_wr('h7FF, 8'(~d1));
    wait_done();
    xf(8, 48'(OP_CLR_WEL));
    xf(32, 48'({OP_WR_ARR, 16'h0000, ~d2}));
    rd3();
    d2 = ~d2;
    wr(32, 48'({OP_WR_ARR, 16'h0000, d2}));
    mdl_wr('h000, d2);
    rd3();
    $display("test array done");
    st_m = 8'hB4;
    wr(16, 48'({OP_WR_STAT, st_m}));
    @(negedge clk_in) lock_n_in = 1'b0;
    xf(8, 48'(OP_SET_WEL));
    xf(16, 48'({OP_WR_STAT, 8'h24}));
    wait_done();
    check({rx[7:2], 2'b00}, st_m);
    @(negedge clk_in) lock_n_in = 1'b1;
    st_m = 8'h24;
    wr(16, 48'({OP_WR_STAT, st_m}));
    $display("test lock done");
    repeat (150) @(negedge clk_in);
    check({7'h00, rst}, 8'h00);
    for (int k = 0; k < 80 && rst !== 1'b1; k++) @(negedge clk_in);
    check({7'h00, rst}, 8'h01);
    $display("test watchdog done");
    end_of_test();
  end
endmodule
